// file: rtl/pcb_pkg.sv
// Constants for the configuration header block: offsets, layouts, resets.
// Assumes byte-addressed configuration accesses of one dword per cycle.
package pcb_pkg;

	// Byte offsets of the registers in configuration space.
	localparam logic [7:0] OFS_TENURE_LINE  = 8'h0c;
	localparam logic [7:0] OFS_HDR_SELFTEST = 8'h0e;
	localparam logic [7:0] OFS_HOST_BASE    = 8'h10;
	localparam logic [7:0] OFS_VEXT_BASE    = 8'h14;

	// Lowest address bit that selects a dword.
	localparam int DWORD_LSB = 2;

	// Field widths and byte lanes of the tenure and line size register.
	localparam int FIELD_W      = 8;
	localparam int LANE_LINE    = 0;
	localparam int LANE_TENURE  = 1;

	// Reset values of the writable fields.
	localparam logic [7:0]  RST_TENURE = 8'h00;
	localparam logic [7:0]  RST_LINE   = 8'h00;
	localparam logic [31:0] RST_BASE   = 32'h0000_0000;

	// Constant read values of the header layout and self-test fields.
	localparam logic [7:0] SELF_TEST_VAL  = 8'h00;
	localparam logic [7:0] HDR_LAYOUT_VAL = 8'h00;

	// Number of low address bits that each window hides (2K and 16K).
	localparam int HOST_SIZE_BITS = 11;
	localparam int VEXT_SIZE_BITS = 14;

	// Bus commands that take the line burst length.
	localparam logic [3:0] CMD_READ_MULTIPLE = 4'hc;
	localparam logic [3:0] CMD_READ_LINE     = 4'he;
	localparam logic [3:0] CMD_WRITE_INVAL   = 4'hf;

endpackage

// file: rtl/pcb_win_if.sv
// Interface between the header block and one memory window decoder.
// Assumes both ends share the block clock.
`timescale 1ns/1ps
interface pcb_win_if;
	logic        wr_en;      // Write strobe for this window's base.
	logic [31:0] wdata;      // Configuration write data.
	logic [3:0]  be;         // Byte enables of the write.
	logic [31:0] bus_addr;   // Address of a target memory access.
	logic        addr_valid; // Address phase of a memory access.
	logic        mem_en;     // Memory space decoding is enabled.
	logic [31:0] base;       // Readback of the base register.
	logic        hit;        // Registered claim of the access.

	// The header block drives the request side.
	modport owner (
		output wr_en, wdata, be, bus_addr, addr_valid, mem_en,
		input  base, hit
	);

	// The window decoder holds the base and answers the claim.
	modport window (
		input  wr_en, wdata, be, bus_addr, addr_valid, mem_en,
		output base, hit
	);
endinterface

// file: rtl/pcb_window.sv
// One memory window: writable base register and address comparator.
// Assumes the owner raises wr_en only for writes to this window's offset.
`timescale 1ns/1ps
module pcb_window #(
	parameter int SIZE_BITS = pcb_pkg::HOST_SIZE_BITS
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Link to the header block.
	pcb_win_if.window win
);
	import pcb_pkg::*;

	// The window must hide the four flag bits and leave one base bit.
	if (SIZE_BITS < 4 || SIZE_BITS > 31)
	begin : g_bad_size
		$error("pcb_window: SIZE_BITS out of range");
	end

	logic [31-SIZE_BITS:0] upper_q; // Writable upper base bits.
	logic                  hit_q;   // Registered claim of the access.

	// Only the bits above the window size take write data, per byte lane.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			upper_q <= RST_BASE[31:SIZE_BITS];
		else if (win.wr_en)
		begin
			for (int b = SIZE_BITS; b < 32; b++)
			begin
				if (win.be[b / 8])
					upper_q[b - SIZE_BITS] <= win.wdata[b];
			end
		end
	end

	// The size field and all flag bits read zero, so all ones reads back
	// as the window mask.
	assign win.base = {upper_q, {SIZE_BITS{1'b0}}};

	// The access is claimed when its upper bits match the base.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			hit_q <= 1'b0;
		else
			hit_q <= win.addr_valid && win.mem_en &&
				(win.bus_addr[31:SIZE_BITS] == upper_q);
	end

	assign win.hit = hit_q;

	// An all-ones write reads back as the size mask next cycle.
	all_ones_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(win.wr_en && win.be == 4'hf && win.wdata == 32'hffff_ffff)
		|=> (win.base == ~((32'h1 << SIZE_BITS) - 32'h1)))
		else $error("window base does not read back its size mask");

	// A matching access is claimed one cycle later, and only then.
	window_claim_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		hit_q == $past(win.addr_valid && win.mem_en &&
			(win.bus_addr[31:SIZE_BITS] == upper_q)))
		else $error("window claim does not follow the address match");

endmodule // pcb_window

// file: rtl/pcb_cfg_bars.sv
// Configuration header slice: bus tenure limit, line size, header type,
// self-test and two memory window base registers.
// Assumes one configuration access per request, dword addressed with
// byte enables, and an initiator engine that reports its bus tenure.
`timescale 1ns/1ps
module pcb_cfg_bars (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Configuration access port.
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata_q,
	output logic             cfg_ack_q,
	// Initiator engine.
	input  wire logic        init_frame_start,
	input  wire logic        init_active,
	input  wire logic        gnt_n,
	input  wire logic [3:0]  init_cmd,
	output logic             tenure_expired_q,
	output logic             init_stop_q,
	output logic      [7:0]  line_burst_length_q,
	output logic      [7:0]  init_line_words_q,
	// Target address decode.
	input  wire logic [31:0] tgt_addr,
	input  wire logic        tgt_addr_valid,
	input  wire logic        mem_space_en,
	output logic             host_ctrl_hit,
	output logic             vendor_ext_hit
);
	import pcb_pkg::*;

	logic [7:0]  dword_addr;   // Access address with lane bits cleared.
	logic        sel_tenure;   // Access selects the tenure/line dword.
	logic        sel_host;     // Access selects the host window base.
	logic        sel_vext;     // Access selects the extension base.
	logic [7:0]  tenure_q;     // Programmed bus tenure limit.
	logic [7:0]  tenure_cnt_q; // Clocks elapsed since frame start.
	logic        tenure_hit;   // Counter has reached the limit.
	logic [31:0] rd_d;         // Read data selected by the address.

	// One link per memory window.
	pcb_win_if host_if ();
	pcb_win_if vext_if ();

	// Dword decode; the header dword shares the tenure dword.
	assign dword_addr = {cfg_addr[7:DWORD_LSB], 2'b00};
	assign sel_tenure = (dword_addr == OFS_TENURE_LINE);
	assign sel_host   = (dword_addr == OFS_HOST_BASE);
	assign sel_vext   = (dword_addr == OFS_VEXT_BASE);

	// Tenure limit, written through its own byte lane.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			tenure_q <= RST_TENURE;
		else if (cfg_wr && sel_tenure && cfg_be[LANE_TENURE])
			tenure_q <= cfg_wdata[LANE_TENURE*FIELD_W +: FIELD_W];
	end

	// Line burst length, written through the low byte lane.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			line_burst_length_q <= RST_LINE;
		else if (cfg_wr && sel_tenure && cfg_be[LANE_LINE])
			line_burst_length_q <=
				cfg_wdata[LANE_LINE*FIELD_W +: FIELD_W];
	end

	// Line burst length is handed to the engine only for line commands.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			init_line_words_q <= 8'h00;
		else if (init_cmd == CMD_READ_MULTIPLE ||
			init_cmd == CMD_READ_LINE || init_cmd == CMD_WRITE_INVAL)
			init_line_words_q <= line_burst_length_q;
		else
			init_line_words_q <= 8'h00;
	end

	// The counter saturates at the limit so that it never wraps past it.
	assign tenure_hit = (tenure_cnt_q == tenure_q);

	// Tenure counter: cleared as frame is asserted, then one per clock.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			tenure_cnt_q <= 8'h00;
		else if (init_frame_start)
			tenure_cnt_q <= 8'h00;
		else if (init_active && !tenure_hit)
			tenure_cnt_q <= tenure_cnt_q + 8'h01;
	end

	// Expiry flag: set while the transaction outlives its tenure.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			tenure_expired_q <= 1'b0;
		else if (init_frame_start || !init_active)
			tenure_expired_q <= 1'b0;
		else
			tenure_expired_q <= tenure_hit;
	end

	// The engine is told to end only once its grant has been taken away;
	// while grant stays, the engine may keep the bus past its tenure.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			init_stop_q <= 1'b0;
		else if (init_frame_start || !init_active)
			init_stop_q <= 1'b0;
		else
			init_stop_q <= tenure_hit && gnt_n;
	end

	// Window links: writes only to each window's own dword.
	assign host_if.wr_en      = cfg_wr && sel_host;
	assign host_if.wdata      = cfg_wdata;
	assign host_if.be         = cfg_be;
	assign host_if.bus_addr   = tgt_addr;
	assign host_if.addr_valid = tgt_addr_valid;
	assign host_if.mem_en     = mem_space_en;
	assign vext_if.wr_en      = cfg_wr && sel_vext;
	assign vext_if.wdata      = cfg_wdata;
	assign vext_if.be         = cfg_be;
	assign vext_if.bus_addr   = tgt_addr;
	assign vext_if.addr_valid = tgt_addr_valid;
	assign vext_if.mem_en     = mem_space_en;

	// Host controller window of 2K bytes.
	pcb_window #(
		.SIZE_BITS (HOST_SIZE_BITS)
	) u_host_win (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.win     (host_if.window)
	);

	// Vendor extension window of 16K bytes.
	pcb_window #(
		.SIZE_BITS (VEXT_SIZE_BITS)
	) u_vext_win (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.win     (vext_if.window)
	);

	// Claims come straight from each window's flip-flop.
	assign host_ctrl_hit  = host_if.hit;
	assign vendor_ext_hit = vext_if.hit;

	// Read mux; unmapped dwords read zero.
	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (1'b1)
			sel_tenure:
				// Upper half holds the fixed header and self-test bytes.
				rd_d = {SELF_TEST_VAL, HDR_LAYOUT_VAL,
					tenure_q, line_burst_length_q};
			sel_host:
				rd_d = host_if.base;
			sel_vext:
				rd_d = vext_if.base;
			default:
				rd_d = 32'h0000_0000;
		endcase
	end

	// Read data is registered and stands for one cycle with the ack.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			cfg_rdata_q <= 32'h0000_0000;
		else if (cfg_rd)
			cfg_rdata_q <= rd_d;
		else
			cfg_rdata_q <= 32'h0000_0000;
	end

	// Every access, mapped or not, is acknowledged one cycle later.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			cfg_ack_q <= 1'b0;
		else
			cfg_ack_q <= cfg_rd || cfg_wr;
	end

	// A frame start leaves the counter at zero on the next edge.
	tenure_restart_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		init_frame_start |=> (tenure_cnt_q == 8'h00))
		else $error("tenure counter did not restart at frame start");

	// A running transaction counts one clock per cycle up to the limit.
	tenure_count_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(init_active && !init_frame_start && !tenure_hit)
		|=> (tenure_cnt_q == $past(tenure_cnt_q) + 8'h01))
		else $error("tenure counter did not advance by one");

	// With a limit of two, stop stands four cycles after frame start
	// when grant is already gone and the transaction stays active.
	tenure_stop_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(init_frame_start && tenure_q == 8'h02 && !cfg_wr) ##1
		(init_active && gnt_n && !init_frame_start && !cfg_wr)[*3]
		|=> init_stop_q)
		else $error("transaction not ended after tenure expiry");

	// No stop is given while grant is still held.
	stop_needs_gnt_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		init_stop_q |-> $past(gnt_n) && $past(tenure_hit))
		else $error("stop raised without expiry and grant removal");

	// A line size write is used by the next line command.
	line_size_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(cfg_wr && sel_tenure && cfg_be[LANE_LINE]) ##1
		(!cfg_wr && init_cmd == CMD_WRITE_INVAL)
		|=> init_line_words_q == $past(cfg_wdata[7:0], 2))
		else $error("line burst length not applied to line command");

	// The header dword's upper half reads zero even after a write to it.
	hdr_zero_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(cfg_rd && sel_tenure) |=> (cfg_rdata_q[31:16] == 16'h0000))
		else $error("self-test or header layout byte not zero");

	// An all-ones write to the host base reads back as the 2K mask.
	host_mask_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(cfg_wr && sel_host && cfg_be == 4'hf &&
			cfg_wdata == 32'hffff_ffff) ##1 (cfg_rd && sel_host && !cfg_wr)
		|=> cfg_rdata_q == 32'hffff_f800)
		else $error("host window base did not read FFFF F800h");

	// An all-ones write to the extension base reads back the 16K mask.
	vext_mask_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(cfg_wr && sel_vext && cfg_be == 4'hf &&
			cfg_wdata == 32'hffff_ffff) ##1 (cfg_rd && sel_vext && !cfg_wr)
		|=> cfg_rdata_q == 32'hffff_c000)
		else $error("extension window base did not read FFFF C000h");

	// The low bits of both bases never read back as ones.
	base_low_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(host_if.base[10:0] == 11'h000) && (vext_if.base[13:0] == 14'h0000))
		else $error("window base low bits not zero");

	// A reached limit during a running transaction raises the expiry flag.
	expiry_flag_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(init_active && !init_frame_start && tenure_hit)
		|=> tenure_expired_q)
		else $error("expiry flag not raised at the tenure limit");

	// A stop is never asked for while the grant is still held.
	stop_held_gnt_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		!gnt_n |=> !init_stop_q)
		else $error("stop raised while grant still held");

	// A stop is only ever given together with the expiry flag.
	stop_with_expiry_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		init_stop_q |-> tenure_expired_q)
		else $error("stop raised without tenure expiry");

	// Commands other than the three line commands get no line length.
	line_words_idle_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		!(init_cmd == CMD_READ_MULTIPLE || init_cmd == CMD_READ_LINE ||
			init_cmd == CMD_WRITE_INVAL) |=> (init_line_words_q == 8'h00))
		else $error("line length handed over for a plain command");

	// A write through the upper lane lands in the tenure limit.
	tenure_write_a: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		(cfg_wr && sel_tenure && cfg_be[LANE_TENURE]) |=>
		(tenure_q == $past(cfg_wdata[LANE_TENURE*FIELD_W +: FIELD_W])))
		else $error("tenure limit write did not land");

endmodule // pcb_cfg_bars

// file: verification/pcb_init_partner.sv
// Model of the bus arbiter and initiator engine around the header block.
// Assumes the block's stop output ends the transaction at the next edge.
`timescale 1ns/1ps
module pcb_init_partner (
	// Clock and reset.
	input  wire logic	ref_clk,
	input  wire logic	rstn,
	// Bench commands.
	input  wire logic	start,
	input  wire logic	take_gnt,
	// Feedback from the block.
	input  wire logic	init_stop_q,
	// Engine and arbiter outputs.
	output logic		frame_start_q,
	output logic		active_q,
	output logic		gnt_n_q
);
	// The frame start lasts one cycle, then the transaction runs until the
	// block asks for it to end; the engine ends it no sooner than that.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			frame_start_q <= 1'b0;
			active_q <= 1'b0;
		end
		else
		begin
			frame_start_q <= start;
			if (frame_start_q)
				active_q <= 1'b1;
			else if (init_stop_q)
				active_q <= 1'b0;
		end
	end

	// The arbiter removes the grant only when the bench asks it to.
	always_ff @(posedge ref_clk)
	begin
		gnt_n_q <= rstn ? take_gnt : 1'b0;
	end
endmodule // pcb_init_partner

// file: verification/pcb_cfg_bars_tb_top.sv
// Self-checking bench for the configuration header block.
// Assumes the partner model drives the initiator-side inputs other than init_cmd, which the bench drives.
`timescale 1ns/1ps
module pcb_cfg_bars_tb_top;
	import pcb_pkg::*;
	logic		ref_clk, rstn, cfg_rd, cfg_wr, start, take_gnt;
	logic		tgt_v, mem_en, ack_q, exp_q, stop_q, fs, act, gnt_n;
	logic		h_hit, v_hit;
	logic [7:0]	cfg_addr, line_q, words_q;
	logic [3:0]	cfg_be, init_cmd;
	logic [31:0]	cfg_wdata, tgt_addr, rdata_q, rd;
	int		fails, n_compared, n;
	// Commands for the line length hand-over, and decode cases.
	logic [3:0]	cmds[4] = '{CMD_READ_MULTIPLE, CMD_READ_LINE,
		CMD_WRITE_INVAL, 4'h7};
	logic [31:0]	ta[7] = '{32'ha0000804, 32'ha0000ffc, 32'ha0001000,
		32'ha0000804, 32'hb000fffc, 32'hb0010000, 32'hb000bffc};
	logic [2:0]	te[7] = '{3'b110, 3'b110, 3'b100, 3'b000, 3'b101,
		3'b100, 3'b100};

	pcb_cfg_bars pcb_cfg_bars_i (.ref_clk(ref_clk), .rstn(rstn),
		.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(rdata_q),
		.cfg_ack_q(ack_q), .init_frame_start(fs), .init_active(act),
		.gnt_n(gnt_n), .init_cmd(init_cmd), .tenure_expired_q(exp_q),
		.init_stop_q(stop_q), .line_burst_length_q(line_q),
		.init_line_words_q(words_q), .tgt_addr(tgt_addr),
		.tgt_addr_valid(tgt_v), .mem_space_en(mem_en),
		.host_ctrl_hit(h_hit), .vendor_ext_hit(v_hit));
	pcb_init_partner pcb_init_partner_i (.ref_clk(ref_clk), .rstn(rstn),
		.start(start), .take_gnt(take_gnt), .init_stop_q(stop_q),
		.frame_start_q(fs), .active_q(act), .gnt_n_q(gnt_n));

	// Free-running 100 MHz clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got,
				exp);
		end
	endtask

	// One configuration access; the answer comes one cycle after it.
	task automatic cfg(input logic w, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d);
		@(posedge ref_clk);
		cfg_wr <= w;
		cfg_rd <= !w;
		cfg_addr <= a;
		cfg_be <= b;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1;
		chk(ack_q, 1, "ack");
		rd = rdata_q;
	endtask

	// Reads a dword and compares it with the expected value.
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		cfg(1'b0, a, 4'h0, 32'h0);
		chk(rd, e, "read");
	endtask

	// All-ones write, then a read of the same dword at the very next edge.
	task automatic wrrd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_be <= 4'hf;
		cfg_wdata <= 32'hffff_ffff;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b1;
		#1;
		chk(ack_q, 1, "write ack");
		@(posedge ref_clk);
		cfg_rd <= 1'b0;
		#1;
		chk(ack_q, 1, "read ack");
		chk(rdata_q, e, "read");
	endtask

	// Runs one transaction; the expiry must land limit plus two edges after
	// the frame start, and a stop needs the grant taken away.
	task automatic tenure(input int lim, input logic drop, input logic pre);
		if (pre)
		begin
			@(posedge ref_clk);
			start <= 1'b1;
			@(posedge ref_clk);
			start <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		start <= 1'b1;
		take_gnt <= drop;
		@(posedge ref_clk);
		start <= 1'b0;
		n = 0;
		#1;
		while (exp_q !== 1'b1 && n < 300)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(n, lim + 2, "tenure");
		chk(stop_q, drop, "stop");
		take_gnt <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		// A stop already given has ended the transaction and fallen again.
		chk(stop_q, !drop, "stop late");
		take_gnt <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	// Watchdog against a hang.
	initial
	begin
		#200us;
		fails++;
		give_verdict();
	end

	// Main sequence.
	initial
	begin
		{rstn, cfg_rd, cfg_wr, start, take_gnt, tgt_v, mem_en} = '0;
		{cfg_addr, cfg_be, cfg_wdata, tgt_addr, init_cmd} = '0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		rchk(8'h0c, 32'h0);
		rchk(8'h10, 32'h0);
		rchk(8'h14, 32'h0);
		cfg(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
		rchk(8'h0e, 32'h0000_ffff);
		@(posedge ref_clk);
		init_cmd <= CMD_WRITE_INVAL;
		cfg(1'b1, 8'h0c, 4'h3, 32'hffff_0310);
		rchk(8'h0c, 32'h0000_0310);
		chk(line_q, 8'h10, "line");
		chk(words_q, 8'h10, "words");
		wrrd(8'h10, 32'hffff_f800);
		wrrd(8'h14, 32'hffff_c000);
		cfg(1'b1, 8'h10, 4'h2, 32'h0);
		rchk(8'h10, 32'hffff_0000);
		cfg(1'b1, 8'h18, 4'hf, 32'hffff_ffff);
		rchk(8'h18, 32'h0);
		foreach (cmds[i])
		begin
			@(posedge ref_clk);
			init_cmd <= cmds[i];
			@(posedge ref_clk);
			#1;
			chk(words_q, i < 3 ? 8'h10 : 8'h0, "words");
		end
		tenure(3, 1'b0, 1'b1);
		tenure(3, 1'b1, 1'b0);
		cfg(1'b1, 8'h0c, 4'h2, 32'h0000_0100);
		tenure(1, 1'b1, 1'b0);
		cfg(1'b1, 8'h0c, 4'h2, 32'h0000_0200);
		tenure(2, 1'b1, 1'b0);
		cfg(1'b1, 8'h10, 4'hf, 32'ha000_0800);
		cfg(1'b1, 8'h14, 4'hf, 32'hb000_c000);
		foreach (ta[i])
		begin
			@(posedge ref_clk);
			tgt_v <= 1'b1;
			tgt_addr <= ta[i];
			mem_en <= te[i][2];
			@(posedge ref_clk);
			tgt_v <= 1'b0;
			#1;
			chk(h_hit, te[i][1], "host hit");
			chk(v_hit, te[i][0], "ext hit");
		end
		give_verdict();
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
endmodule // pcb_cfg_bars_tb_top
